// [hw/adc_conversion_sequencer.sv]
// Overview of operation
// [RQ1] software bit or event starts conversion
// [RQ2] scan steps positive input once per conversion
// [RQ3] converter clock from prescaled peripheral clock
// [RQ4] new sample accepted every converter cycle
// [RQ5] latency one plus half resolution plus gain
// [RQ6] gain stage adds one converter cycle; the code adds gain_code plus one half cycles
// [RQ7] msb first, then one bit per half
// [RQ8] last cycle: result ready, flag set
// [RQ9] trigger one pclk before converter cycle
// [RQ10] input sampled in first half cycle
// [RQ11] each gain doubling adds half cycle
// [RQ12] completion or compare raises interrupt, event
// [RQ13] writable linearity calibration, software loads it
// [RQ14] flush restarts clock, next pclk converts
// [RQ15] flushed conversions give no result
// [RQ16] flush by software or configured event
// [RQ17] flush triggers spaced beyond latency
// [RQ18] pending starts launch right after flush
// [RQ19] sampling extendable by half cycles
// [RQ20] start bit cleared when conversion starts
// [RQ21] pending conversions complete after flush
// [RQ22] scan end returns to first input
`default_nettype none
module adc_conversion_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_event,
    input wire logic [11:0] core_result,
    output logic conv_clk,
    output logic sample,
    output logic [3:0] input_sel,
    output logic gain_en,
    output logic [2:0] gain_code,
    output logic res_8bit,
    output logic [7:0] calib,
    output logic irq,
    output logic done_event
);
    // ----------------------------------------
    // latency in half cycles
    // ----------------------------------------
    function automatic logic [5:0] lat_of(input logic r8, input logic ge,
        input logic [2:0] gc, input logic [3:0] ext);
        logic [5:0] g;
        g = ge ? 6'({3'h0, gc} + 6'h01) : 6'h00; // [RQ6] [RQ11]
        lat_of = 6'(adc_seq_pkg::LAT_FIXED + (r8 ? adc_seq_pkg::LAT_RES8
            : adc_seq_pkg::LAT_RES12) + g + {2'h0, ext}); // [RQ5] [RQ7] [RQ19]
    endfunction : lat_of

    conv_clk_if ck ();

    conv_clk_gen u_clk (
        .pclk(pclk),
        .presetn(presetn),
        .ck(ck.gen)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic en_q;
    logic channel_zero_start_bit_q;
    logic ev_pend_q;
    logic freerun_q;
    logic [2:0] evact_q;
    logic [2:0] presc_q;
    logic [3:0] first_q;
    logic [3:0] count_q;
    logic [3:0] sample_extension_count_q;
    logic [11:0] cmp_q;
    logic [1:0] cmp_mode_q;
    logic ie_q;
    logic flag_q;
    logic flag_d;
    logic [11:0] result_q;
    logic [3:0] res_src_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic scan_active_q;
    logic [3:0] cur_in_q;
    logic [3:0] left_q;
    logic [3:0] samp_left_q;
    logic sample_q;
    logic conv_clk_q;
    logic [3:0] input_select_register_q;
    logic gain_en_q;
    logic [2:0] gain_code_q;
    logic res8_q;
    logic [7:0] calib_q;
    logic irq_q;
    logic done_event_q;
    logic [adc_seq_pkg::STAGES-1:0] stg_v_q;
    logic [3:0] stg_in_q [adc_seq_pkg::STAGES];

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire logic [3:0] idx = paddr[5:2];
    wire logic hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
        && (idx <= adc_seq_pkg::IDX_STATUS);
    wire logic acc = psel & penable & pready_q;
    wire logic wr = acc & pwrite & hit;
    wire logic wr_ctrl = wr && (idx == adc_seq_pkg::IDX_CTRL);
    wire logic wr_flags = wr && (idx == adc_seq_pkg::IDX_INTFLAGS);
    wire logic start_wr = wr_ctrl & pwdata[adc_seq_pkg::CTRL_START];
    wire logic flush_sw = wr_ctrl & pwdata[adc_seq_pkg::CTRL_FLUSH];
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (idx)
            adc_seq_pkg::IDX_CTRL: rd_mux = {29'h0, channel_zero_start_bit_q, 1'b0, en_q};
            adc_seq_pkg::IDX_CFG: rd_mux = {25'h0, gain_code_q, 1'b0, gain_en_q,
                freerun_q, res8_q};
            adc_seq_pkg::IDX_EVCTRL: rd_mux = {29'h0, evact_q};
            adc_seq_pkg::IDX_PRESC: rd_mux = {29'h0, presc_q};
            adc_seq_pkg::IDX_INSEL: rd_mux = {24'h0, count_q, first_q};
            adc_seq_pkg::IDX_SAMP: rd_mux = {28'h0, sample_extension_count_q};
            adc_seq_pkg::IDX_CALIB: rd_mux = {24'h0, calib_q};
            adc_seq_pkg::IDX_CMP: rd_mux = {20'h0, cmp_q};
            adc_seq_pkg::IDX_INTCTRL: rd_mux = {29'h0, ie_q, cmp_mode_q};
            adc_seq_pkg::IDX_INTFLAGS: rd_mux = {31'h0, flag_q};
            adc_seq_pkg::IDX_RESULT: rd_mux = {20'h0, result_q};
            adc_seq_pkg::IDX_STATUS: rd_mux = {20'h0, res_src_q, cur_in_q,
                2'h0, ev_pend_q, scan_active_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            prdata_q <= hit ? rd_mux : 32'h0000_0000;
            pslverr_q <= ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            freerun_q <= 1'b0;
            res8_q <= 1'b0;
            gain_en_q <= 1'b0;
            gain_code_q <= 3'h0;
            evact_q <= adc_seq_pkg::EVACT_NONE;
            presc_q <= 3'h0;
            first_q <= 4'h0;
            count_q <= 4'h0;
            sample_extension_count_q <= 4'h0;
            calib_q <= 8'h00;
            cmp_q <= 12'h000;
            cmp_mode_q <= adc_seq_pkg::CMPM_DONE;
            ie_q <= 1'b0;
        end else if (wr) begin
            unique case (idx)
                adc_seq_pkg::IDX_CTRL: en_q <= pwdata[adc_seq_pkg::CTRL_EN];
                adc_seq_pkg::IDX_CFG: begin
                    res8_q <= pwdata[adc_seq_pkg::CFG_RES8];
                    freerun_q <= pwdata[adc_seq_pkg::CFG_FREERUN];
                    gain_en_q <= pwdata[adc_seq_pkg::CFG_GAIN_EN];
                    gain_code_q <= pwdata[adc_seq_pkg::CFG_GAIN_LO +: 3];
                end
                adc_seq_pkg::IDX_EVCTRL: evact_q <= pwdata[2:0];
                adc_seq_pkg::IDX_PRESC: presc_q <= pwdata[2:0];
                adc_seq_pkg::IDX_INSEL: begin
                    first_q <= pwdata[3:0];
                    count_q <= pwdata[7:4];
                end
                adc_seq_pkg::IDX_SAMP: sample_extension_count_q <= pwdata[3:0]; // [RQ19]
                adc_seq_pkg::IDX_CALIB: calib_q <= pwdata[7:0]; // [RQ13]
                adc_seq_pkg::IDX_CMP: cmp_q <= pwdata[11:0];
                adc_seq_pkg::IDX_INTCTRL: begin
                    cmp_mode_q <= pwdata[1:0];
                    ie_q <= pwdata[2];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // triggers and flush
    // ----------------------------------------
    wire logic ev_ch0 = start_event && (evact_q == adc_seq_pkg::EVACT_CH0);
    wire logic ev_sync = start_event && (evact_q == adc_seq_pkg::EVACT_SYNC);
    wire logic flush_req = en_q & (flush_sw | ev_sync); // [RQ16]
    wire logic samp_end = ck.half_tick && (samp_left_q == 4'h0);
    wire logic samp_busy = sample_q & ~samp_end;
    // triggers are registered first, so they need one pclk of lead
    wire logic want = scan_active_q | channel_zero_start_bit_q | ev_pend_q | freerun_q; // [RQ9]
    wire logic launch = en_q & ~flush_req & ck.cycle_start & ~samp_busy & want; // [RQ4]
    wire logic consume = launch & ~scan_active_q;
    wire logic [3:0] used_in = scan_active_q ? cur_in_q : first_q;
    wire logic [3:0] remain = scan_active_q ? left_q : count_q;
    wire logic more = (remain != 4'h0);

    assign ck.flush = flush_req; // [RQ14]
    assign ck.presc = presc_q;

    // pending starts survive a flush on purpose, so they launch right after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_zero_start_bit_q <= 1'b0;
            ev_pend_q <= 1'b0;
        end else begin
            channel_zero_start_bit_q <= start_wr
                | (channel_zero_start_bit_q & ~consume); // [RQ1] [RQ20] [RQ18]
            ev_pend_q <= (ev_ch0 | ev_sync) | (ev_pend_q & ~consume); // [RQ1] [RQ21]
        end
    end

    // ----------------------------------------
    // scan and sampling
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_active_q <= 1'b0;
            cur_in_q <= 4'h0;
            left_q <= 4'h0;
            input_select_register_q <= 4'h0;
        end else if (!en_q) begin
            scan_active_q <= 1'b0;
            cur_in_q <= first_q;
        end else if (launch) begin
            input_select_register_q <= used_in;
            scan_active_q <= more;
            cur_in_q <= more ? 4'(used_in + 4'h1) : first_q; // [RQ2] [RQ22]
            left_q <= more ? 4'(remain - 4'h1) : 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_q <= 1'b0;
            samp_left_q <= 4'h0;
        end else if (flush_req || !en_q) begin
            sample_q <= 1'b0;
            samp_left_q <= 4'h0;
        end else if (launch) begin
            sample_q <= 1'b1; // [RQ10]
            samp_left_q <= sample_extension_count_q; // [RQ19]
        end else if (ck.half_tick && sample_q) begin
            sample_q <= ~samp_end;
            samp_left_q <= 4'(samp_left_q - 4'h1);
        end
    end

    // ----------------------------------------
    // conversion pipeline, one stage per half cycle
    // ----------------------------------------
    wire logic [5:0] lat = lat_of(res8_q, gain_en_q, gain_code_q, sample_extension_count_q);
    wire logic [5:0] tap = 6'(lat - 6'h01);
    wire logic comp = en_q & ~flush_req & ck.half_tick & stg_v_q[tap]; // [RQ8]
    wire logic [11:0] res_val = res8_q ? {4'h0, core_result[11:4]} : core_result;
    wire logic cmp_hit = (cmp_mode_q == adc_seq_pkg::CMPM_DONE)
        || ((cmp_mode_q == adc_seq_pkg::CMPM_BELOW) && (res_val < cmp_q))
        || ((cmp_mode_q == adc_seq_pkg::CMPM_ABOVE) && (res_val > cmp_q));
    wire logic hit_evt = comp & cmp_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_v_q <= '0;
        end else if (flush_req || !en_q) begin
            stg_v_q <= '0; // [RQ15]
        end else if (ck.half_tick) begin
            stg_v_q <= {stg_v_q[adc_seq_pkg::STAGES-2:0], launch}; // [RQ4]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < adc_seq_pkg::STAGES; i++) begin
                stg_in_q[i] <= 4'h0;
            end
        end else if (ck.half_tick) begin
            stg_in_q[0] <= used_in;
            for (int i = 1; i < adc_seq_pkg::STAGES; i++) begin
                stg_in_q[i] <= stg_in_q[i-1];
            end
        end
    end

    // ----------------------------------------
    // result, flag, outputs
    // ----------------------------------------
    assign flag_d = hit_evt | (flag_q & ~(wr_flags & pwdata[0])); // [RQ12]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 12'h000;
            res_src_q <= 4'h0;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
            done_event_q <= 1'b0;
            conv_clk_q <= 1'b0;
        end else begin
            if (comp) begin
                result_q <= res_val; // [RQ8]
                res_src_q <= stg_in_q[tap];
            end
            flag_q <= flag_d;
            irq_q <= flag_d & ie_q; // [RQ12]
            done_event_q <= hit_evt;
            conv_clk_q <= ck.half_tick ? ~ck.first_half : conv_clk_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign conv_clk = conv_clk_q;
    assign sample = sample_q;
    assign input_sel = input_select_register_q;
    assign gain_en = gain_en_q;
    assign gain_code = gain_code_q;
    assign res_8bit = res8_q;
    assign calib = calib_q;
    assign irq = irq_q;
    assign done_event = done_event_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_flush;
        flush_req;
    endsequence
    sequence s_restart;
        ck.cycle_start && stg_v_q == '0;
    endsequence

    chk_flush_restart: assert property (s_flush |=> s_restart) // [RQ14] [RQ15]
        else $error("flush did not restart clock or clear pipeline");
    chk_start_clear: assert property (launch && !scan_active_q && !start_wr
        |=> !channel_zero_start_bit_q) // [RQ20]
        else $error("start bit not cleared at launch");
    chk_sample_first: assert property (launch |=> sample_q && ck.first_half) // [RQ10]
        else $error("sample not in first half");
    chk_latency_base: assert property (!gain_en_q && sample_extension_count_q == 4'h0
        |-> lat == (res8_q ? 6'h0a : 6'h0e)) // [RQ5]
        else $error("base latency wrong");
    chk_gain_half: assert property (gain_en_q
        |-> lat == 6'((res8_q ? 6'h0a : 6'h0e) + {3'h0, gain_code_q}
        + {2'h0, sample_extension_count_q} + 6'h01)) // [RQ11] [RQ6]
        else $error("gain latency wrong");
    chk_done_flag: assert property (comp && cmp_mode_q == adc_seq_pkg::CMPM_DONE
        |=> flag_q && result_q == $past(res_val) ##1 (irq == ie_q)) // [RQ8] [RQ12]
        else $error("completion flag or result missing");
    chk_scan_step: assert property (launch && more |=> cur_in_q == 4'($past(used_in) + 4'h1)
        && input_sel == $past(used_in)) // [RQ2]
        else $error("scan did not advance");
    chk_scan_wrap: assert property (launch && !more |=> cur_in_q == first_q) // [RQ22]
        else $error("scan did not return to first input");
    chk_event_start: assert property (en_q && ev_ch0 |=> ev_pend_q || sample_q) // [RQ1]
        else $error("event start lost");
endmodule : adc_conversion_sequencer
`default_nettype wire

// [hw/adc_seq_pkg.sv]
`default_nettype none
package adc_seq_pkg;
    // ----------------------------------------
    // register word indices (paddr[5:2]), byte offset is four times the index
    // ----------------------------------------
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_CFG = 4'h1;
    localparam logic [3:0] IDX_EVCTRL = 4'h2;
    localparam logic [3:0] IDX_PRESC = 4'h3;
    localparam logic [3:0] IDX_INSEL = 4'h4;
    localparam logic [3:0] IDX_SAMP = 4'h5;
    localparam logic [3:0] IDX_CALIB = 4'h6;
    localparam logic [3:0] IDX_CMP = 4'h7;
    localparam logic [3:0] IDX_INTCTRL = 4'h8;
    localparam logic [3:0] IDX_INTFLAGS = 4'h9;
    localparam logic [3:0] IDX_RESULT = 4'ha;
    localparam logic [3:0] IDX_STATUS = 4'hb;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_FLUSH = 1;
    localparam int CTRL_START = 2;
    localparam int CFG_RES8 = 0;
    localparam int CFG_FREERUN = 1;
    localparam int CFG_GAIN_EN = 2;
    localparam int CFG_GAIN_LO = 4;
    // ----------------------------------------
    // event modes and compare modes
    // ----------------------------------------
    localparam logic [2:0] EVACT_NONE = 3'h0;
    localparam logic [2:0] EVACT_CH0 = 3'h1;
    localparam logic [2:0] EVACT_SYNC = 3'h6;
    localparam logic [1:0] CMPM_DONE = 2'h0;
    localparam logic [1:0] CMPM_BELOW = 2'h1;
    localparam logic [1:0] CMPM_ABOVE = 2'h2;
    // ----------------------------------------
    // timing, in converter half cycles (HALF_BASE in pclk cycles)
    // ----------------------------------------
    localparam logic [5:0] LAT_FIXED = 6'h02;
    localparam logic [5:0] LAT_RES8 = 6'h08;
    localparam logic [5:0] LAT_RES12 = 6'h0c;
    localparam int STAGES = 40;
    localparam logic [8:0] HALF_BASE = 9'h002;
endpackage : adc_seq_pkg
`default_nettype wire

// [hw/conv_clk_gen.sv]
`default_nettype none
module conv_clk_gen (
    input wire logic pclk,
    input wire logic presetn,
    conv_clk_if.gen ck
);
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    logic second_q;
    logic second_d;
    wire logic [8:0] reload;

    // ----------------------------------------
    // half period is 2^(presc+1) pclk cycles
    // ----------------------------------------
    assign reload = 9'((adc_seq_pkg::HALF_BASE << ck.presc) - 9'h001); // [RQ3]
    assign ck.half_tick = (cnt_q == 9'h000);
    assign ck.cycle_start = ck.half_tick & second_q;
    assign ck.first_half = ~second_q;

    // flush forces a cycle start on the very next pclk
    assign cnt_d = ck.flush ? 9'h000 : (ck.half_tick ? reload : cnt_q - 9'h001); // [RQ14]
    assign second_d = ck.flush ? 1'b1 : (ck.half_tick ? ~second_q : second_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 9'h000;
            second_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            second_q <= second_d;
        end
    end
endmodule : conv_clk_gen
`default_nettype wire

// [hw/conv_clk_if.sv]
`default_nettype none
interface conv_clk_if;
    logic flush;
    logic [2:0] presc;
    logic half_tick;
    logic cycle_start;
    logic first_half;
    modport gen (input flush, input presc, output half_tick, output cycle_start,
        output first_half);
    modport user (output flush, output presc, input half_tick, input cycle_start,
        input first_half);
endinterface : conv_clk_if
`default_nettype wire

// [tb/core_partner.sv]
`default_nettype none
module core_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample,
    input wire logic [3:0] input_sel,
    output logic [11:0] core_result = 12'h000,
    output logic start_event = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_q = 1'b0;
    // ----------------------------------------
    // analogue core: value tied to sampled input
    // ----------------------------------------
    // only the newest sample is held, so scans are not checked on result
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
            core_result <= 12'h000;
        end else begin
            seen_q <= sample;
            if (sample && !seen_q) begin
                core_result <= {input_sel, 8'ha5};
            end
        end
    end
    // ----------------------------------------
    // event trigger, one pclk pulse
    // ----------------------------------------
    // callers wait for completion first, so flushes never cut a result
    task fire;
        @(posedge pclk);
        start_event <= 1'b1;
        @(posedge pclk);
        start_event <= 1'b0;
    endtask : fire
endmodule : core_partner
`default_nettype wire

// [tb/test_adc_conversion_sequencer.sv]
`default_nettype none
module test_adc_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, start_event, conv_clk, sample, irq, done_event;
    logic [11:0] core_result;
    logic [3:0] input_sel;
    logic [7:0] calib;
    logic gain_en, res_8bit;
    logic [2:0] gain_code;
    logic s_prev = 1'b0;
    logic c_prev = 1'b0;
    logic [31:0] rv;
    logic re;
    int mismatches = 0;
    int check_count = 0;
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        s_prev <= sample;
        c_prev <= conv_clk;
    end
    adc_conversion_sequencer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_event(start_event),
        .core_result(core_result), .conv_clk(conv_clk), .sample(sample),
        .input_sel(input_sel), .gain_en(gain_en), .gain_code(gain_code), .res_8bit(res_8bit),
        .calib(calib), .irq(irq), .done_event(done_event));
    core_partner partner_u (.pclk(pclk), .presetn(presetn), .sample(sample),
        .input_sel(input_sel), .core_result(core_result), .start_event(start_event));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task fail(input string m);
        mismatches++;
        $display("unexpected at %0t: %s", $time, m);
        summarize();
    endtask : fail
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail("no pready");
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [3:0] i, input logic [31:0] d);
        apb(1'b1, {6'h00, i, 2'b00}, d);
    endtask : wr
    task rd(input logic [3:0] i);
        apb(1'b0, {6'h00, i, 2'b00}, 32'h0);
    endtask : rd
    // rising edge of conv_clk (ck=1) or of sample (ck=0)
    task automatic wait_rise(input logic ck, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(ck ? (conv_clk === 1'b1 && c_prev === 1'b0)
                        : (sample === 1'b1 && s_prev === 1'b0)) && n < 300);
        if (n >= 300) fail("no rising edge");
    endtask : wait_rise
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300) fail("no irq");
    endtask : wait_irq
    task automatic conv(input logic [31:0] cfg, input logic [31:0] ext, output int n);
        int m;
        wr(adc_seq_pkg::IDX_CFG, cfg);
        wr(adc_seq_pkg::IDX_SAMP, ext);
        wr(adc_seq_pkg::IDX_INTFLAGS, 32'h1);
        wr(adc_seq_pkg::IDX_CTRL, 32'h5);
        wait_rise(1'b0, m);
        wait_irq(n);
    endtask : conv
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        chk({irq, sample, conv_clk, input_sel}, 32'h0, "outputs after reset");
        wr(adc_seq_pkg::IDX_CALIB, 32'h5c);
        rd(adc_seq_pkg::IDX_CALIB);
        chk(calib, 32'h5c, "calib port");
        chk(rv, 32'h5c, "calib readback");
        apb(1'b0, 12'h030, 32'h0);
        chk(re, 32'h1, "unmapped error");
        chk(rv, 32'h0, "unmapped read");
        apb(1'b0, 12'h006, 32'h0);
        chk(re, 32'h1, "misaligned read");
        wr(adc_seq_pkg::IDX_INTCTRL, 32'h4);
        $display("test regs done");
    endtask : t_regs
    task automatic t_clk;
        int n;
        wr(adc_seq_pkg::IDX_CTRL, 32'h1);
        for (int p = 0; p < 3; p++) begin
            wr(adc_seq_pkg::IDX_PRESC, p);
            wait_rise(1'b1, n);
            wait_rise(1'b1, n);
            wait_rise(1'b1, n);
            chk(n, 4 << p, "converter clock period");
        end
        wr(adc_seq_pkg::IDX_PRESC, 32'h0);
        $display("test clock done");
    endtask : t_clk
    task automatic t_lat;
        int b, n;
        conv(32'h0, 32'h0, b);
        chk(b >= 28 && b <= 32, 32'h1, "12-bit latency");
        rd(adc_seq_pkg::IDX_RESULT);
        chk(rv, 32'h0a5, "12-bit result");
        rd(adc_seq_pkg::IDX_CTRL);
        chk(rv[2], 32'h0, "start bit cleared");
        conv(32'h1, 32'h0, n);
        chk(n, b - 8, "8-bit latency");
        rd(adc_seq_pkg::IDX_RESULT);
        chk(rv, 32'h00a, "8-bit result");
        conv(32'h14, 32'h0, n);
        chk(n, b + 4, "gain 1x latency");
        conv(32'h34, 32'h0, n);
        chk(n, b + 8, "gain code 3 latency");
        chk({gain_en, gain_code, res_8bit}, 32'h16, "gain and resolution ports");
        conv(32'h0, 32'h3, n);
        chk(n, b + 6, "extended sampling latency");
        $display("test latency done");
    endtask : t_lat
    task automatic t_scan;
        int n;
        wr(adc_seq_pkg::IDX_SAMP, 32'h0);
        wr(adc_seq_pkg::IDX_INSEL, 32'h23);
        wr(adc_seq_pkg::IDX_CTRL, 32'h5);
        wait_rise(1'b0, n);
        chk(input_sel, 32'h3, "first scan input");
        for (int k = 1; k < 3; k++) begin
            wait_rise(1'b0, n);
            chk(input_sel, 3 + k, "scan input step");
            chk(n, 4, "one sample per converter cycle");
        end
        wr(adc_seq_pkg::IDX_CTRL, 32'h5);
        wait_rise(1'b0, n);
        chk(input_sel, 32'h3, "scan wraps to first");
        $display("test scan done");
    endtask : t_scan
    task automatic t_flush;
        int n, e;
        wr(adc_seq_pkg::IDX_INSEL, 32'h0);
        repeat (60) @(posedge pclk);
        wr(adc_seq_pkg::IDX_INTFLAGS, 32'h1);
        wr(adc_seq_pkg::IDX_CTRL, 32'h5);
        wait_rise(1'b0, n);
        wr(adc_seq_pkg::IDX_CTRL, 32'h3);
        e = 0;
        for (int k = 0; k < 60; k++) begin
            @(posedge pclk);
            if (irq !== 1'b0) e++;
        end
        chk(e, 0, "flushed conversion flagged");
        wr(adc_seq_pkg::IDX_CTRL, 32'h7);
        wait_rise(1'b0, n);
        chk(n <= 3, 32'h1, "launch right after flush");
        wait_irq(n);
        chk(n, 28, "pending conversion completes");
        $display("test flush done");
    endtask : t_flush
    task automatic t_event;
        int n;
        wr(adc_seq_pkg::IDX_INTFLAGS, 32'h1);
        wr(adc_seq_pkg::IDX_EVCTRL, 32'h1);
        partner_u.fire();
        wait_rise(1'b0, n);
        chk(n <= 12, 32'h1, "event starts conversion");
        wait_irq(n);
        wr(adc_seq_pkg::IDX_INTFLAGS, 32'h1);
        wr(adc_seq_pkg::IDX_EVCTRL, 32'h6);
        partner_u.fire();
        wait_rise(1'b0, n);
        chk(n <= 3, 32'h1, "event flush launches at once");
        wait_irq(n);
        wr(adc_seq_pkg::IDX_EVCTRL, 32'h0);
        $display("test event done");
    endtask : t_event
    task automatic t_cmp;
        int n, d;
        wr(adc_seq_pkg::IDX_CMP, 32'h100);
        for (int m = 1; m < 3; m++) begin
            wr(adc_seq_pkg::IDX_INTFLAGS, 32'h1);
            wr(adc_seq_pkg::IDX_INTCTRL, 4 | m);
            wr(adc_seq_pkg::IDX_CTRL, 32'h5);
            wait_rise(1'b0, n);
            d = 0;
            for (int k = 0; k < 60; k++) begin
                @(posedge pclk);
                if (done_event === 1'b1) d++;
            end
            chk({irq, d[7:0]}, m == 1 ? 32'h101 : 32'h0, "compare irq and event");
        end
        wr(adc_seq_pkg::IDX_CFG, 32'h2);
        wait_rise(1'b0, n);
        wait_rise(1'b0, n);
        chk(n, 4, "free running launches");
        wr(adc_seq_pkg::IDX_CFG, 32'h0);
        $display("test compare done");
    endtask : t_cmp
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_clk();
        t_lat();
        t_scan();
        t_flush();
        t_event();
        t_cmp();
        summarize();
    end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
